// >>> logic/wlu_bitcell.sv
`timescale 1ns/1ns
// One bit position of the logic array
module wlu_bitcell (
    // Operand bits
    input wire logic i_a,
    input wire logic i_b,
    // Function select
    input wire wlu_pkg::wlu_fn_t i_fn,
    // Result bit
    output logic o_y
);
    // Each function looks only at its own position
    assign o_y = (i_fn == wlu_pkg::WLU_FN_AND) ? (i_a & i_b) :
                 (i_fn == wlu_pkg::WLU_FN_OR) ? (i_a | i_b) :
                 (i_a ^ i_b);
endmodule

// >>> logic/wlu_pkg.sv
package wlu_pkg;
    // Operand and result widths
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    // Function codes as the sequencer presents them (decimal figures, hex literals)
    localparam logic [9:0] OPC_AND_SINGLE = 10'h022; // 034
    localparam logic [9:0] OPC_OR_SINGLE = 10'h023; // 035
    localparam logic [9:0] OPC_XOR_SINGLE = 10'h024; // 036
    localparam logic [9:0] OPC_AND_DOUBLE = 10'h262; // 610
    localparam logic [9:0] OPC_OR_DOUBLE = 10'h263; // 611
    localparam logic [9:0] OPC_XOR_DOUBLE = 10'h264; // 612
    // Bit positions of the flags and word halves
    localparam int MSB_SINGLE = 15;
    localparam int MSB_DOUBLE = 31;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    // Logic function selector
    typedef enum logic [1:0] {
        WLU_FN_AND,
        WLU_FN_OR,
        WLU_FN_XOR
    } wlu_fn_t;
endpackage

// >>> logic/wlu_word_logic_unit.sv
`timescale 1ns/1ns
// How it works
// - single AND gives bitwise AND of words
// - double AND combines two 32-bit pairs
// - single OR sets bit if either set
// - single XOR sets bit where inputs differ
// - double XOR over full 32-bit pairs
// - single forms bitwise, any operand source
// - double forms bitwise, any operand source
// - error flag always cleared after execution
// - equals flag set when result zero
// - negative flag copies result top bit
module wlu_word_logic_unit (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Request from the sequencer
    input wire logic i_exec,
    input wire logic [9:0] i_opcode,
    input wire logic [15:0] i_operand_a_lo,
    input wire logic [15:0] i_operand_a_hi,
    input wire logic [15:0] i_operand_b_lo,
    input wire logic [15:0] i_operand_b_hi,
    // Write-back to word storage
    output logic o_wr_valid,
    output logic o_wr_double,
    output logic [15:0] o_result_lo,
    output logic [15:0] o_result_hi,
    // Condition flags
    output logic o_error_flag,
    output logic o_equals_flag,
    output logic o_negative_flag,
    // Opcode not handled here
    output logic o_unknown
);
    // Opcode decode used for both validity and width
    function automatic logic op_known(input logic [9:0] op);
        op_known = (op == wlu_pkg::OPC_AND_SINGLE) || (op == wlu_pkg::OPC_OR_SINGLE)
            || (op == wlu_pkg::OPC_XOR_SINGLE) || (op == wlu_pkg::OPC_AND_DOUBLE)
            || (op == wlu_pkg::OPC_OR_DOUBLE) || (op == wlu_pkg::OPC_XOR_DOUBLE);
    endfunction

    function automatic logic op_double(input logic [9:0] op);
        op_double = (op == wlu_pkg::OPC_AND_DOUBLE) || (op == wlu_pkg::OPC_OR_DOUBLE)
            || (op == wlu_pkg::OPC_XOR_DOUBLE);
    endfunction

    // Decoded request
    wire logic known = op_known(i_opcode);
    wire logic is_double = op_double(i_opcode);
    wire logic fire = i_exec && known;
    wlu_pkg::wlu_fn_t fn;

    // Function from opcode; AND is the fallback for unknown codes, unused then
    always_comb begin
        case (i_opcode)
            wlu_pkg::OPC_OR_SINGLE, wlu_pkg::OPC_OR_DOUBLE: fn = wlu_pkg::WLU_FN_OR;
            wlu_pkg::OPC_XOR_SINGLE, wlu_pkg::OPC_XOR_DOUBLE: fn = wlu_pkg::WLU_FN_XOR;
            default: fn = wlu_pkg::WLU_FN_AND;
        endcase
    end

    // Low word at bits 15..0, next word at 31..16
    wire logic [31:0] a_full = {i_operand_a_hi, i_operand_a_lo};
    wire logic [31:0] b_full = {i_operand_b_hi, i_operand_b_lo};
    logic [31:0] y_full;

    // One cell per bit; constants arrive as operand words like any other source
    genvar g;
    generate
        for (g = 0; g < wlu_pkg::DWORD_W; g++) begin : g_bits
            wlu_bitcell u_cell (
                .i_a(a_full[g]),
                .i_b(b_full[g]),
                .i_fn(fn),
                .o_y(y_full[g])
            );
        end
    endgenerate

    // Single forms leave the high word zero so the flags see only 16 bits
    wire logic [31:0] next_result = is_double ? y_full
        : {16'h0000, y_full[wlu_pkg::MSB_SINGLE:0]};
    wire logic next_equals = (next_result == 32'h0000_0000);
    wire logic next_negative = is_double ? y_full[wlu_pkg::MSB_DOUBLE]
        : y_full[wlu_pkg::MSB_SINGLE];

    // Result and flags update only on an executed known opcode
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            {o_result_hi, o_result_lo} <= wlu_pkg::RESULT_RESET;
            o_equals_flag <= 1'b0;
            o_negative_flag <= 1'b0;
            o_error_flag <= 1'b0;
            o_wr_double <= 1'b0;
        end else if (fire) begin
            {o_result_hi, o_result_lo} <= next_result;
            o_equals_flag <= next_equals;
            o_negative_flag <= next_negative;
            o_error_flag <= 1'b0;
            o_wr_double <= is_double;
        end
    end

    // Write strobe and unknown pulse, one cycle each
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_wr_valid <= 1'b0;
            o_unknown <= 1'b0;
        end else begin
            o_wr_valid <= fire;
            o_unknown <= i_exec && !known;
        end
    end

    // Assertions, all on the one clock and reset of the unit

    // Single AND lands in the low word one cycle after the take
    property p_and_single;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_AND_SINGLE)
        |=> o_result_lo == ($past(i_operand_a_lo) & $past(i_operand_b_lo));
    endproperty
    a_and_single: assert property (p_and_single)
        else $error("single AND result wrong");

    // Double AND covers both words of the pair
    property p_and_double;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_AND_DOUBLE)
        |=> {o_result_hi, o_result_lo} == ($past(a_full) & $past(b_full));
    endproperty
    a_and_double: assert property (p_and_double)
        else $error("double AND result wrong");

    // Single OR in the low word
    property p_or_single;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_OR_SINGLE)
        |=> o_result_lo == ($past(i_operand_a_lo) | $past(i_operand_b_lo));
    endproperty
    a_or_single: assert property (p_or_single)
        else $error("single OR result wrong");

    // Single XOR in the low word
    property p_xor_single;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_XOR_SINGLE)
        |=> o_result_lo == ($past(i_operand_a_lo) ^ $past(i_operand_b_lo));
    endproperty
    a_xor_single: assert property (p_xor_single)
        else $error("single XOR result wrong");

    // Double XOR covers both words of the pair
    property p_xor_double;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_XOR_DOUBLE)
        |=> {o_result_hi, o_result_lo} == ($past(a_full) ^ $past(b_full));
    endproperty
    a_xor_double: assert property (p_xor_double)
        else $error("double XOR result wrong");

    // Single forms never leave stale bits in the high word
    property p_single_hi_zero;
        @(posedge i_clock) disable iff (i_rst)
        (fire && !is_double) |=> o_result_hi == 16'h0000 && !o_wr_double;
    endproperty
    a_single_hi_zero: assert property (p_single_hi_zero)
        else $error("single form touched high word");

    // Double OR combines the full pair as well
    property p_or_double;
        @(posedge i_clock) disable iff (i_rst)
        (i_exec && i_opcode == wlu_pkg::OPC_OR_DOUBLE)
        |=> {o_result_hi, o_result_lo} == ($past(a_full) | $past(b_full));
    endproperty
    a_or_double: assert property (p_or_double)
        else $error("double OR result wrong");

    // Storage must know that two words are to be written
    property p_double_flag;
        @(posedge i_clock) disable iff (i_rst)
        (fire && is_double) |=> o_wr_double && o_wr_valid;
    endproperty
    a_double_flag: assert property (p_double_flag)
        else $error("double form not marked");

    // No operand combination is an error for these functions
    property p_error_clear;
        @(posedge i_clock) disable iff (i_rst)
        o_wr_valid |-> !o_error_flag;
    endproperty
    a_error_clear: assert property (p_error_clear)
        else $error("error flag set after logic op");

    // Equals follows the whole written value
    property p_equals;
        @(posedge i_clock) disable iff (i_rst)
        o_wr_valid |-> o_equals_flag == ({o_result_hi, o_result_lo} == 32'h0000_0000);
    endproperty
    a_equals: assert property (p_equals)
        else $error("equals flag wrong");

    // Negative follows the top bit of whichever width was written
    property p_negative;
        @(posedge i_clock) disable iff (i_rst)
        o_wr_valid |-> o_negative_flag == (o_wr_double ? o_result_hi[wlu_pkg::MSB_SINGLE]
            : o_result_lo[wlu_pkg::MSB_SINGLE]);
    endproperty
    a_negative: assert property (p_negative)
        else $error("negative flag wrong");

    // Nothing moves and nothing is written without a taken request
    property p_hold;
        @(posedge i_clock) disable iff (i_rst)
        !fire |=> $stable(o_result_lo) && $stable(o_result_hi)
            && $stable(o_equals_flag) && $stable(o_negative_flag)
            && $stable(o_wr_double) && !o_wr_valid;
    endproperty
    a_hold: assert property (p_hold)
        else $error("state changed without execution");

    // Main scenarios
    c_single: cover property (@(posedge i_clock) disable iff (i_rst) fire && !is_double);
    c_double: cover property (@(posedge i_clock) disable iff (i_rst) fire && is_double);
    c_zero: cover property (@(posedge i_clock) disable iff (i_rst) o_wr_valid && o_equals_flag);
    c_neg: cover property (@(posedge i_clock) disable iff (i_rst) o_wr_valid && o_negative_flag);
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the word logic unit
module tb_top;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic exec;
    logic [9:0] opc;
    logic [31:0] a, b;
    // Two result ports drive separate halves, so a net
    wire [31:0] res;
    logic valid, dbl, err, eq, neg, unk;
    int err_count = 0;
    int n_compared = 0;
    // Last result the unit should be holding
    logic [31:0] last_r = '0;
    logic last_d = 1'b0;
    // 100 ns period
    always #50 i_clock = ~i_clock;
    wlu_seq_model i_seq (.o_exec(exec), .o_opcode(opc), .o_a(a), .o_b(b));
    wlu_word_logic_unit i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_exec(exec),
        .i_opcode(opc), .i_operand_a_lo(a[15:0]), .i_operand_a_hi(a[31:16]),
        .i_operand_b_lo(b[15:0]), .i_operand_b_hi(b[31:16]), .o_wr_valid(valid),
        .o_wr_double(dbl), .o_result_lo(res[15:0]), .o_result_hi(res[31:16]),
        .o_error_flag(err), .o_equals_flag(eq), .o_negative_flag(neg), .o_unknown(unk));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One request, judged just after the edge that takes it
    task automatic do_op(input logic ex, input logic [9:0] op, input logic [31:0] x, y);
        logic [31:0] r;
        logic d;
        logic ok;
        ok = 1'b1;
        d = (op == wlu_pkg::OPC_AND_DOUBLE) || (op == wlu_pkg::OPC_OR_DOUBLE)
            || (op == wlu_pkg::OPC_XOR_DOUBLE);
        case (op)
            wlu_pkg::OPC_AND_SINGLE, wlu_pkg::OPC_AND_DOUBLE: r = x & y;
            wlu_pkg::OPC_OR_SINGLE, wlu_pkg::OPC_OR_DOUBLE: r = x | y;
            wlu_pkg::OPC_XOR_SINGLE, wlu_pkg::OPC_XOR_DOUBLE: r = x ^ y;
            default: ok = 1'b0;
        endcase
        // Single forms leave the upper word clear
        if (!d) r[31:16] = 16'h0000;
        i_seq.issue(ex, op, x, y);
        @(posedge i_clock);
        #1;
        if (ex && ok) begin
            last_r = r;
            last_d = d;
        end
        check(valid, ex && ok);
        check(unk, ex && !ok);
        check(res, last_r);
        check(dbl, last_d);
        check(err, 1'b0);
        check(eq, last_r == 32'h0);
        check(neg, last_d ? last_r[31] : last_r[15]);
    endtask
    // Single forms back to back, upper words ignored
    task automatic t_single();
        do_op(1'b1, wlu_pkg::OPC_AND_SINGLE, 32'hFFFF_F0F0, 32'h1234_8F00);
        do_op(1'b1, wlu_pkg::OPC_OR_SINGLE, 32'h0000_0000, 32'hABCD_0000);
        do_op(1'b1, wlu_pkg::OPC_XOR_SINGLE, 32'h0000_5A5A, 32'h0000_A5A4);
        do_op(1'b1, wlu_pkg::OPC_XOR_SINGLE, 32'h0000_5A5A, 32'h0000_5A5A);
    endtask
    // Double forms; bit 15 set must not count as negative
    task automatic t_double();
        do_op(1'b1, wlu_pkg::OPC_AND_DOUBLE, 32'h8001_0000, 32'hFFFF_FFFF);
        do_op(1'b1, wlu_pkg::OPC_OR_DOUBLE, 32'h0000_8000, 32'h0000_0001);
        do_op(1'b1, wlu_pkg::OPC_XOR_DOUBLE, 32'hFFFF_0000, 32'h0F0F_00FF);
        do_op(1'b1, wlu_pkg::OPC_XOR_DOUBLE, 32'h1234_5678, 32'h1234_5678);
    endtask
    // False condition and unknown code both leave the result alone
    task automatic t_hold();
        do_op(1'b1, wlu_pkg::OPC_OR_SINGLE, 32'h0000_00F0, 32'h0000_0F00);
        do_op(1'b0, wlu_pkg::OPC_AND_DOUBLE, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        do_op(1'b1, 10'h025, 32'h0000_0000, 32'h0000_0000);
    endtask
    // Reset in mid-run clears everything, then work resumes
    task automatic t_reset();
        i_rst = 1'b1;
        #10;
        check({valid, dbl, err, eq, neg, unk}, 32'h0);
        check(res, 32'h0);
        @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        do_op(1'b1, wlu_pkg::OPC_AND_SINGLE, 32'h0000_0000, 32'h0000_FFFF);
    endtask
    // Single exit for both outcomes
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Run is about sixteen cycles; limit is far beyond that
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        t_single();
        t_double();
        t_hold();
        t_reset();
        give_verdict();
    end
endmodule

// >>> verif/wlu_seq_model.sv
`timescale 1ns/1ns
// Sequencer stand-in, one request per call
module wlu_seq_model (
    // Request to the unit
    output logic o_exec,
    output logic [9:0] o_opcode,
    output logic [31:0] o_a,
    output logic [31:0] o_b
);
    // Idle at time zero
    initial {o_exec, o_opcode, o_a, o_b} = '0;
    // Caller stands just after an edge; bits 15..0 are the first word
    task automatic issue(input logic ex, input logic [9:0] op, input logic [31:0] a, b);
        o_exec = ex;
        o_opcode = op;
        // Idle operands scrambled so a stale value proves nothing
        o_a = ex ? a : ~o_a;
        o_b = ex ? b : ~o_b;
    endtask
endmodule
